/* test/dcfc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module dcfc_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Device control and status
	input wire logic mac_full_duplex_select_in,
	input wire logic phy_loopback_enable_in,
	input wire logic [1:0] flow_ctl_enable_in,
	input wire logic transmit_request_out,
	input wire logic transmit_aborted_flag_out,
	input wire logic tx_error_out,
	input wire logic jamming_out,
	input wire logic link_up_out,
	// Medium
	input wire logic dev_tx_valid,
	input wire logic [7:0] dev_tx_data,
	input wire logic dev_carrier,
	input wire logic node_tx_valid
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	logic fd;
	assign fd = mac_full_duplex_select_in;

	jam_pattern_a: assert property (jamming_out |-> dev_tx_valid && dev_tx_data == 8'h55)
		else $error("jam byte wrong");
	jam_full_a: assert property (fd |-> !jamming_out)
		else $error("jam in full duplex");
	jam_stop_a: assert property (!flow_ctl_enable_in[0] |=> !jamming_out)
		else $error("jam did not stop");
	jam_yield_a: assert property (jamming_out && transmit_request_out |=> !jamming_out)
		else $error("jam kept during request");
	jam_resume_a: assert property ($fell(transmit_request_out) && !fd && flow_ctl_enable_in[0] |-> ##[0:2] jamming_out)
		else $error("jam did not resume");
	abort_event_a: assert property ($rose(transmit_aborted_flag_out) |-> tx_error_out && !transmit_request_out)
		else $error("abort without error or request");
	error_once_a: assert property (tx_error_out |=> !tx_error_out)
		else $error("error pulse too long");
	error_flag_a: assert property (tx_error_out |-> transmit_aborted_flag_out)
		else $error("error without abort flag");
	full_clean_a: assert property (fd |-> !tx_error_out)
		else $error("abort in full duplex");
	loop_quiet_a: assert property (fd && phy_loopback_enable_in |-> !dev_tx_valid && !dev_carrier && !link_up_out)
		else $error("line active in loopback");
	back_off_a: assert property (!fd && dev_carrier && !jamming_out && node_tx_valid |=> !dev_carrier || jamming_out)
		else $error("kept sending in collision");
	defer_a: assert property (!fd && node_tx_valid && !dev_carrier |=> !dev_carrier || jamming_out)
		else $error("started on busy medium");

	jam_c: cover property (jamming_out);
	abort_c: cover property ($rose(transmit_aborted_flag_out));
	both_c: cover property (fd && dev_tx_valid && node_tx_valid);
endmodule

`default_nettype wire

/* test/dcfc_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module duplex_collision_flow_control_tb;
	import dcfc_pkg::*;
	logic clk_in = 0, rst_in = 1, mac = 0, phy = 0, hdl = 0, plb = 0, set = 0, nfd = 0, ren = 1;
	logic ntv = 0, ntl = 0, rdy = 1, req, abf, err, shd, mis, jam, lnk, drv, nrv, ntr, rbz, ncol;
	logic [1:0] fce = 0;
	logic [3:0] rlim = 4'h3;
	logic [5:0] cwin = 6'h3f;
	logic [6:0] gap = 7'h05;
	logic [10:0] len = 0, fadr;
	logic [7:0] ntd = 0, fcr, drd, nrd, fdat;
	logic [7:0] dq[$], nq[$];
	int miscompares = 0, num_checks = 0, ecnt = 0, ccnt = 0, k, c;

	always #12.5 clk_in = ~clk_in;
	assign fdat = 8'h10 + fadr[7:0];
	// Outputs are collected mid-cycle, where every registered value has settled.
	always @(negedge clk_in) begin
		if (drv === 1'b1) dq.push_back(drd);
		if (nrv === 1'b1) nq.push_back(nrd);
		if (err === 1'b1) ecnt++;
		if (ncol === 1'b1) ccnt++;
	end

	dcfc_link_if dcfc_link_if_i ();
	dcfc_device dcfc_device_i (.clk_in(clk_in), .rst_in(rst_in), .mac_full_duplex_select_in(mac),
		.phy_duplex_select_in(phy), .half_duplex_loopback_disable_in(hdl), .phy_loopback_enable_in(plb),
		.flow_ctl_enable_in(fce), .receive_enable_in(ren), .retry_limit_in(rlim), .collision_window_in(cwin),
		.back_to_back_gap_in(gap), .transmit_request_set_in(set), .tx_length_in(len), .tx_fetch_addr_out(fadr),
		.tx_fetch_data_in(fdat), .transmit_request_out(req), .transmit_aborted_flag_out(abf), .tx_error_out(err),
		.full_duplex_shadow_out(shd), .flow_ctl_reg_out(fcr), .duplex_mismatch_out(mis), .jamming_out(jam),
		.link_up_out(lnk), .rx_valid_out(drv), .rx_data_out(drd), .receive_in_progress_out(rbz), .link(dcfc_link_if_i));
	dcfc_node dcfc_node_i (.clk_in(clk_in), .rst_in(rst_in), .full_duplex_in(nfd), .tx_valid_in(ntv),
		.tx_data_in(ntd), .tx_last_in(ntl), .tx_ready_out(ntr), .rx_valid_out(nrv), .rx_data_out(nrd),
		.rx_ready_in(rdy), .collision_out(ncol), .link(dcfc_link_if_i));
	dcfc_checker dcfc_checker_i (.clk_in(clk_in), .rst_in(rst_in), .mac_full_duplex_select_in(mac),
		.phy_loopback_enable_in(plb), .flow_ctl_enable_in(fce), .transmit_request_out(req),
		.transmit_aborted_flag_out(abf), .tx_error_out(err), .jamming_out(jam), .link_up_out(lnk),
		.dev_tx_valid(dcfc_link_if_i.dev_tx_valid), .dev_tx_data(dcfc_link_if_i.dev_tx_data),
		.dev_carrier(dcfc_link_if_i.dev_carrier), .node_tx_valid(dcfc_link_if_i.node_tx_valid));

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask

	// Requests a frame of n bytes and waits, bounded, for the request to drop.
	task automatic send(input int n, input int lim);
		int w;
		len = 11'(n);
		set = 1;
		tick(1);
		set = 0;
		w = 0;
		while (req !== 1'b0 && w < lim) begin
			tick(1);
			w++;
		end
		chk1(req, 1'b0);
	endtask

	task automatic node_send(input int n, input logic [7:0] b);
		int w;
		for (int i = 0; i < n; i++) begin
			ntv = 1;
			ntd = b + 8'(i);
			ntl = (i == n - 1);
			w = 0;
			while (ntr !== 1'b1 && w < 100) begin
				tick(1);
				w++;
			end
			chk1(w < 100, 1'b1);
			tick(1);
		end
		ntv = 0;
	endtask

	task automatic wait_nq(input int n);
		k = 0;
		while (nq.size() < n && k < 200) begin
			tick(1);
			k++;
		end
		chk1(k < 200, 1'b1);
	endtask

	task clr;
		dq.delete();
		nq.delete();
	endtask

	task conclude;
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(25 * 40000);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge clk_in);
		#2;
		rst_in = 0;
		tick(1);
		chk1(shd, 1'b0);
		chk8(fcr, 8'h00);
		clr();
		rdy = 0;
		// The node stalls first so the two-entry buffer must hold its bytes.
		fork
			send(3, 300);
			begin
				tick(10);
				chk1(rbz, 1'b1);
				rdy = 1;
			end
		join
		tick(3);
		chk8(8'(nq.size()), 8'h03);
		chk8(nq[2], 8'h12);
		chk8(8'(dq.size()), 8'h03);
		chk8(dq[0], 8'h10);
		hdl = 1;
		clr();
		send(2, 200);
		tick(3);
		chk8(8'(dq.size()), 8'h00);
		clr();
		fork
			node_send(8, 8'h80);
			begin
				tick(2);
				send(2, 400);
			end
		join
		tick(3);
		chk1(abf, 1'b0);
		chk8(8'(nq.size()), 8'h02);
		chk8(8'(dq.size()), 8'h08);
		chk8(8'(ccnt), 8'h00);
		// A full duplex node on the half duplex medium makes the collisions.
		nfd = 1;
		cwin = 6'h02;
		clr();
		fork
			send(8, 400);
			begin
				wait_nq(3);
				node_send(1, 8'hc0);
			end
		join
		tick(1);
		chk1(abf, 1'b1);
		chk8(8'(ecnt), 8'h01);
		cwin = 6'h3f;
		// The third frame follows a retried one, so a stale retry count would abort it.
		for (int r = 0; r < 3; r++) begin
			rlim = (r == 0) ? 4'h0 : 4'h1;
			clr();
			fork
				send(8, 5000);
				begin
					wait_nq(1);
					node_send(1, 8'hc0);
				end
			join
			tick(3);
			chk1(abf, r == 0);
			chk8(8'(ecnt), 8'h02);
		end
		chk8(nq[$], 8'h17);
		// Receive is shut off and the request idle while the duplex bits disagree.
		ren = 0;
		tick(1);
		chk1(rbz, 1'b0);
		chk1(req, 1'b0);
		mac = 1;
		tick(1);
		chk1(mis, 1'b1);
		phy = 1;
		cwin = 6'h00;
		tick(2);
		chk1(shd, 1'b1);
		chk8(fcr, 8'h04);
		ren = 1;
		clr();
		fork
			send(3, 300);
			node_send(3, 8'ha0);
		join
		tick(3);
		chk1(abf, 1'b0);
		chk8(8'(nq.size()), 8'h03);
		chk8(8'(dq.size()), 8'h03);
		chk8(dq[0], 8'ha0);
		plb = 1;
		clr();
		send(3, 300);
		tick(3);
		chk8(8'(dq.size()), 8'h03);
		chk8(dq[2], 8'h12);
		chk8(8'(nq.size()), 8'h00);
		chk1(lnk, 1'b0);
		ren = 0;
		tick(1);
		chk1(rbz, 1'b0);
		plb = 0;
		mac = 0;
		phy = 0;
		nfd = 0;
		tick(3);
		ren = 1;
		// Only two nodes share this closed medium, so jamming it harms no other traffic.
		for (int m = 0; m < 4; m++) begin
			fce = 2'(m);
			tick(3);
			chk1(jam, m[0]);
			chk8(fcr, 8'(m));
		end
		fce = 2'b01;
		tick(3);
		c = 0;
		fork
			send(2, 300);
			repeat (30) begin
				tick(1);
				if (jam === 1'b0 && dcfc_link_if_i.dev_carrier === 1'b0 && req === 1'b1) c++;
			end
		join
		chk8(8'(c), 8'h06);
		tick(3);
		chk1(jam, 1'b1);
		fce = 2'b00;
		tick(2);
		chk1(jam, 1'b0);
		conclude();
	end
endmodule

`default_nettype wire

/* verilog/dcfc_device.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - Both duplex bits clear gives half duplex.
// RQ2 - Both duplex bits set gives full duplex.
// RQ3 - Host keeps both duplex bits equal.
// RQ4 - Host idles transmit and receive while switching.
// RQ5 - No negotiation; full duplex set by hand.
// RQ6 - Half duplex defers while the medium is busy.
// RQ7 - Early collision: keep request, back off, restart.
// RQ8 - Retry limit reached: abort, clear request, flag.
// RQ9 - Every abort raises the transmit error event.
// RQ10 - Late collision aborts at once, no retry.
// RQ11 - Half duplex loops own frames back by default.
// RQ12 - Loopback disable bit stops half duplex looping.
// RQ13 - Full duplex: concurrent, no collisions, no retries.
// RQ14 - Full duplex loops back only when enabled.
// RQ15 - Full duplex loopback kills driver, line, link.
// RQ16 - Looped frames take the normal receive path.
// RQ17 - Half duplex low enable jams with preamble.
// RQ18 - Request during jam: stop, gap, then send.
// RQ19 - Jamming resumes after the frame ends.
// RQ20 - Clearing low enable ends jamming.
// RQ21 - Host jams only closed, tested networks.
// RQ22 - Shadow bit mirrors the MAC duplex bit.
// RQ23 - Half duplex jam on for codes 11, 01.
// RQ24 - Retry count clears on each accepted request.
module dcfc_device
	import dcfc_pkg::*;
#(
	parameter int LEN_W = 11,
	parameter int FIFO_DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Host control bits
	input wire logic mac_full_duplex_select_in,
	input wire logic phy_duplex_select_in,
	input wire logic half_duplex_loopback_disable_in,
	input wire logic phy_loopback_enable_in,
	input wire logic [1:0] flow_ctl_enable_in,
	input wire logic receive_enable_in,
	input wire logic [DCFC_RETRY_W-1:0] retry_limit_in,
	input wire logic [DCFC_COLLISION_WINDOW_W-1:0] collision_window_in,
	input wire logic [DCFC_GAP_W-1:0] back_to_back_gap_in,
	// Transmit request and frame fetch
	input wire logic transmit_request_set_in,
	input wire logic [LEN_W-1:0] tx_length_in,
	output logic [LEN_W-1:0] tx_fetch_addr_out,
	input wire logic [7:0] tx_fetch_data_in,
	// Status
	output logic transmit_request_out,
	output logic transmit_aborted_flag_out,
	output logic tx_error_out,
	output logic full_duplex_shadow_out,
	output logic [7:0] flow_ctl_reg_out,
	output logic duplex_mismatch_out,
	output logic jamming_out,
	output logic link_up_out,
	// Received bytes toward the filters
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic receive_in_progress_out,
	// Medium
	dcfc_link_if.device link
);

	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

	dcfc_tx_state_e state_reg, state_next;
	logic req_reg, req_next;
	logic abort_reg, abort_next;
	logic err_reg, err_next;
	logic [DCFC_RETRY_W-1:0] retry_reg, retry_next;
	logic [LEN_W-1:0] idx_reg, idx_next;
	logic [LEN_W-1:0] sent_reg, sent_next;
	logic [DCFC_GAP_W-1:0] gap_reg, gap_next;
	logic [DCFC_BACKOFF_CAP-1:0] slot_reg, slot_next;
	logic [DCFC_SLOT_W-1:0] cyc_reg, cyc_next;
	logic [15:0] lfsr_reg, lfsr_next;
	logic [7:0] mem_reg [FIFO_DEPTH];
	logic [7:0] mem_next [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic rx_valid_reg, rx_valid_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic rx_busy_reg, rx_busy_next;

	logic full_mode, jam_on, loop_on, driver_en, medium_busy, collision;
	logic push, pop, flush, finish;
	logic [DCFC_RETRY_W-1:0] k;
	logic [DCFC_BACKOFF_CAP-1:0] mask;

	// Duplex follows the two select bits directly, with no negotiation. [RQ1] [RQ2] [RQ5]
	assign full_mode = mac_full_duplex_select_in && phy_duplex_select_in;
	// Unequal bits are undefined; the logic then acts as half duplex. [RQ3]
	assign duplex_mismatch_out = mac_full_duplex_select_in ^ phy_duplex_select_in;
	assign jam_on = !full_mode && flow_ctl_enable_in[DCFC_FCEN_LOW_BIT]; // [RQ17] [RQ23]
	assign loop_on = full_mode ? phy_loopback_enable_in : !half_duplex_loopback_disable_in; // [RQ11] [RQ12] [RQ14]
	assign driver_en = !(full_mode && phy_loopback_enable_in); // [RQ15]
	assign link_up_out = driver_en; // [RQ15]
	assign medium_busy = !full_mode && link.node_tx_valid; // [RQ6]
	assign collision = !full_mode && (state_reg == ST_SEND) && link.node_tx_valid; // [RQ13]

	assign push = (state_reg == ST_SEND) && !collision && (idx_reg < tx_length_in) && (cnt_reg < CNT_W'(FIFO_DEPTH));
	// A stalled receiver holds the buffer; with the driver off bytes drain into loopback only.
	assign pop = (state_reg == ST_SEND) && !collision && (cnt_reg != '0) && (link.dev_tx_ready || !driver_en);

	assign link.dev_carrier = driver_en && ((state_reg == ST_SEND) || (state_reg == ST_JAM));
	assign link.dev_tx_valid = driver_en && (((state_reg == ST_SEND) && (cnt_reg != '0)) || (state_reg == ST_JAM));
	assign link.dev_tx_data = (state_reg == ST_JAM) ? DCFC_PREAMBLE : mem_reg[rd_reg]; // [RQ17]

	assign tx_fetch_addr_out = idx_reg;
	assign transmit_request_out = req_reg;
	assign transmit_aborted_flag_out = abort_reg;
	assign tx_error_out = err_reg;
	assign full_duplex_shadow_out = mac_full_duplex_select_in; // [RQ22]
	always_comb begin
		flow_ctl_reg_out = DCFC_FLOW_CTL_RST;
		flow_ctl_reg_out[DCFC_SHADOW_BIT] = mac_full_duplex_select_in; // [RQ22]
		flow_ctl_reg_out[DCFC_FCEN_HIGH_BIT] = flow_ctl_enable_in[1];
		flow_ctl_reg_out[DCFC_FCEN_LOW_BIT] = flow_ctl_enable_in[0];
	end
	assign jamming_out = (state_reg == ST_JAM);
	assign rx_valid_out = rx_valid_reg;
	assign rx_data_out = rx_data_reg;
	assign receive_in_progress_out = rx_busy_reg;

	// Backoff window doubles per retry up to the cap.
	always_comb begin
		k = retry_reg + DCFC_RETRY_W'(1);
		if (k >= DCFC_RETRY_W'(DCFC_BACKOFF_CAP)) begin
			mask = '1;
		end else begin
			mask = DCFC_BACKOFF_CAP'((11'h001 << k) - 11'h001);
		end
	end

	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		abort_next = abort_reg;
		err_next = 1'b0;
		retry_next = retry_reg;
		idx_next = idx_reg;
		sent_next = sent_reg;
		gap_next = gap_reg;
		slot_next = slot_reg;
		cyc_next = cyc_reg;
		lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		flush = 1'b0;
		finish = 1'b0;

		// A new request resets the per-frame retry allowance and the abort flag.
		if (transmit_request_set_in && !req_reg) begin
			req_next = 1'b1;
			abort_next = 1'b0;
			retry_next = '0; // [RQ24]
		end

		if (push) begin
			mem_next[wr_reg] = tx_fetch_data_in;
			wr_next = (wr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_reg + PTR_W'(1);
			idx_next = idx_reg + LEN_W'(1);
		end
		if (pop) begin
			rd_next = (rd_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_reg + PTR_W'(1);
			sent_next = sent_reg + LEN_W'(1);
		end
		cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);

		case (state_reg)
			ST_IDLE: begin
				if (req_reg) begin
					state_next = medium_busy ? ST_DEFER : ST_SEND; // [RQ6] [RQ13]
					flush = 1'b1;
				end else if (jam_on) begin
					state_next = ST_JAM; // [RQ17]
				end
			end
			ST_JAM: begin
				if (!jam_on) begin
					state_next = ST_IDLE; // [RQ20]
				end else if (req_reg) begin
					state_next = ST_GAP; // [RQ18]
					gap_next = back_to_back_gap_in;
				end
			end
			ST_GAP: begin
				if (gap_reg == '0) begin
					// Others may start in the gap; the attempt goes ahead and collides normally.
					state_next = ST_SEND; // [RQ18]
					flush = 1'b1;
				end else begin
					gap_next = gap_reg - DCFC_GAP_W'(1);
				end
			end
			ST_DEFER: begin
				if (!medium_busy) begin
					state_next = ST_SEND; // [RQ6]
					flush = 1'b1;
				end
			end
			ST_SEND: begin
				if (collision) begin
					if (sent_reg >= LEN_W'(collision_window_in)) begin
						finish = 1'b1; // [RQ10]
						abort_next = 1'b1;
					end else if (retry_reg == retry_limit_in) begin
						finish = 1'b1; // [RQ8]
						abort_next = 1'b1;
					end else begin
						retry_next = retry_reg + DCFC_RETRY_W'(1); // [RQ7]
						slot_next = lfsr_reg[DCFC_BACKOFF_CAP-1:0] & mask;
						cyc_next = '0;
						state_next = ST_BACKOFF;
						flush = 1'b1;
					end
				end else if ((idx_reg == tx_length_in) && (cnt_reg == '0)) begin
					finish = 1'b1;
				end
			end
			ST_BACKOFF: begin
				if (slot_reg == '0) begin
					state_next = medium_busy ? ST_DEFER : ST_SEND; // [RQ7]
					flush = 1'b1;
				end else if (cyc_reg == DCFC_SLOT_W'(DCFC_SLOT_CYCLES - 1)) begin
					cyc_next = '0;
					slot_next = slot_reg - DCFC_BACKOFF_CAP'(1);
				end else begin
					cyc_next = cyc_reg + DCFC_SLOT_W'(1);
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase

		if (finish) begin
			req_next = 1'b0; // [RQ8]
			err_next = abort_next; // [RQ9]
			flush = 1'b1;
			state_next = jam_on ? ST_JAM : ST_IDLE; // [RQ19]
		end
		// Every attempt starts the frame over from its first byte.
		if (flush) begin
			idx_next = '0; // [RQ7]
			sent_next = '0;
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end
	end

	// Looped bytes win over line bytes; in half duplex both at once is a collision anyway.
	always_comb begin
		rx_valid_next = 1'b0;
		rx_data_next = rx_data_reg;
		if (receive_enable_in) begin
			if (loop_on && pop) begin
				rx_valid_next = 1'b1; // [RQ11] [RQ14] [RQ16]
				rx_data_next = mem_reg[rd_reg];
			end else if (driver_en && link.node_tx_valid) begin
				rx_valid_next = 1'b1; // [RQ13] [RQ15]
				rx_data_next = link.node_tx_data;
			end
		end
		rx_busy_next = receive_enable_in && ((loop_on && (state_reg == ST_SEND)) || (driver_en && link.node_tx_valid));
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			req_reg <= 1'b0;
			abort_reg <= 1'b0;
			err_reg <= 1'b0;
			retry_reg <= '0;
			idx_reg <= '0;
			sent_reg <= '0;
			gap_reg <= '0;
			slot_reg <= '0;
			cyc_reg <= '0;
			lfsr_reg <= DCFC_LFSR_SEED;
			mem_reg <= '{default: 8'h00};
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			rx_busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			abort_reg <= abort_next;
			err_reg <= err_next;
			retry_reg <= retry_next;
			idx_reg <= idx_next;
			sent_reg <= sent_next;
			gap_reg <= gap_next;
			slot_reg <= slot_next;
			cyc_reg <= cyc_next;
			lfsr_reg <= lfsr_next;
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			rx_valid_reg <= rx_valid_next;
			rx_data_reg <= rx_data_next;
			rx_busy_reg <= rx_busy_next;
		end
	end

endmodule

`default_nettype wire

/* verilog/dcfc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Shared medium between the controller and the remote node, both on one clock.
interface dcfc_link_if;
	logic dev_tx_valid;
	logic [7:0] dev_tx_data;
	logic dev_tx_ready;
	logic dev_carrier;
	logic node_tx_valid;
	logic [7:0] node_tx_data;

	modport device (
		output dev_tx_valid,
		output dev_tx_data,
		output dev_carrier,
		input dev_tx_ready,
		input node_tx_valid,
		input node_tx_data
	);

	modport node (
		input dev_tx_valid,
		input dev_tx_data,
		input dev_carrier,
		output dev_tx_ready,
		output node_tx_valid,
		output node_tx_data
	);
endinterface

`default_nettype wire

/* verilog/dcfc_node.sv */
`timescale 1ns/1ps
`default_nettype none

module dcfc_node
	import dcfc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Configuration
	input wire logic full_duplex_in,
	// Frame to send
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_last_in,
	output logic tx_ready_out,
	// Frames heard from the controller
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic rx_ready_in,
	// Status
	output logic collision_out,
	// Medium
	dcfc_link_if.node link
);

	dcfc_node_state_e state_reg, state_next;
	logic out_valid_reg, out_valid_next;
	logic [7:0] out_data_reg, out_data_next;
	logic rx_valid_reg, rx_valid_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic coll_reg, coll_next;
	logic take;

	assign tx_ready_out = (state_reg != NS_IDLE);
	assign take = tx_valid_in && tx_ready_out;
	assign link.node_tx_valid = out_valid_reg;
	assign link.node_tx_data = out_data_reg;
	assign link.dev_tx_ready = rx_ready_in;
	assign rx_valid_out = rx_valid_reg;
	assign rx_data_out = rx_data_reg;
	assign collision_out = coll_reg;

	always_comb begin
		state_next = state_reg;
		out_valid_next = 1'b0;
		out_data_next = out_data_reg;
		coll_next = 1'b0;
		rx_valid_next = link.dev_tx_valid && rx_ready_in;
		rx_data_next = (link.dev_tx_valid && rx_ready_in) ? link.dev_tx_data : rx_data_reg;
		case (state_reg)
			NS_IDLE: begin
				// Full duplex is set by hand here too; there is no negotiation. [RQ5]
				if (tx_valid_in && (full_duplex_in || !link.dev_carrier)) begin
					state_next = NS_SEND;
				end
			end
			NS_SEND: begin
				if (!full_duplex_in && link.dev_carrier && out_valid_reg) begin
					// The rest of a colliding frame is swallowed rather than sent.
					coll_next = 1'b1;
					state_next = (take && tx_last_in) ? NS_IDLE : NS_DROP;
				end else if (take) begin
					out_valid_next = 1'b1;
					out_data_next = tx_data_in;
					if (tx_last_in) begin
						state_next = NS_IDLE;
					end
				end
			end
			NS_DROP: begin
				if (take && tx_last_in) begin
					state_next = NS_IDLE;
				end
			end
			default: begin
				state_next = NS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= NS_IDLE;
			out_valid_reg <= 1'b0;
			out_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			coll_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			out_valid_reg <= out_valid_next;
			out_data_reg <= out_data_next;
			rx_valid_reg <= rx_valid_next;
			rx_data_reg <= rx_data_next;
			coll_reg <= coll_next;
		end
	end

endmodule

`default_nettype wire

/* verilog/dcfc_pkg.sv */
package dcfc_pkg;

	// Flow control register layout: shadow bit and the two enable bits.
	localparam int DCFC_SHADOW_BIT = 2;
	localparam int DCFC_FCEN_HIGH_BIT = 1;
	localparam int DCFC_FCEN_LOW_BIT = 0;
	localparam logic [7:0] DCFC_FLOW_CTL_RST = 8'h00;

	// Jamming preamble byte of alternating ones and zeros.
	localparam logic [7:0] DCFC_PREAMBLE = 8'h55;

	// Backoff slot of 512 bit times at 10 Mb/s, as a count of 40 MHz cycles.
	localparam int DCFC_CLK_PERIOD_NS = 25;
	localparam int DCFC_SLOT_TIME_NS = 51200;
	localparam int DCFC_SLOT_CYCLES = (DCFC_SLOT_TIME_NS + DCFC_CLK_PERIOD_NS - 1) / DCFC_CLK_PERIOD_NS;
	localparam int DCFC_SLOT_W = $clog2(DCFC_SLOT_CYCLES);
	localparam int DCFC_BACKOFF_CAP = 10;

	// Field widths of the host settings.
	localparam int DCFC_RETRY_W = 4;
	localparam int DCFC_COLLISION_WINDOW_W = 6;
	localparam int DCFC_GAP_W = 7;

	// Seed of the backoff random generator; any nonzero value works.
	localparam logic [15:0] DCFC_LFSR_SEED = 16'hace1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_JAM,
		ST_GAP,
		ST_DEFER,
		ST_SEND,
		ST_BACKOFF
	} dcfc_tx_state_e;

	typedef enum logic [1:0] {
		NS_IDLE,
		NS_SEND,
		NS_DROP
	} dcfc_node_state_e;

endpackage
